//--- pci_cfg_gpio_power_regs.sv
// Vendor configuration registers: extended pins, codec-link power control, config bytes, legacy irq map.
// Assumes config cycles are decoded upstream into single-cycle requests on the PCI clock.
//
// Overview of operation
// - Pin A bit: polarity as input, type as output.
// - Pin A sticky latches edge; else live level.
// - Pin A wake needs sticky, not secondary input.
// - Pin B driven only while output enabled.
// - Pin B bit: polarity or output type.
// - Pin B sticky latches edge; else live level.
// - Pin B wake with sticky raises event.
// - Link power register survives bus reset.
// - Codec reset while bit low or bus reset.
// - Force-sync bit drives sync high directly.
// - Primary input rise, link down, sets flag.
// - Secondary input rise, link down, sets flag.
// - Primary codec interrupt rise, with wake enable, raises event.
// - Secondary codec interrupt rise, with secondary input and wake enable, raises event.
// - Disable bit stops the EEPROM engine and blocks its load into the config bytes.
// - Enable bit selects shared pin function.
// - Four config bytes, low byte first, inert.
// - Writes accepted only with write permission.
// - Mirror aux support and power into capability.
// - Mirror aux current code into capability.
// - Trap disable bit blocks all trapping.
// - Zero irq map keeps pin high-impedance.
`timescale 1ns/1ps

module pci_cfg_gpio_power_regs #(
	parameter int SYNC_STAGES = 2
) (
	input  wire logic                                      clk_sys,
	input  wire logic                                      rst_n,
	input  wire logic                                      powerOnRst_n,
	input  wire logic                                      clkEn,
	input  wire pci_cfg_gpio_power_regs_pkg::cfg_req_t     cfgReq,
	input  wire logic                                      configWritePermission,
	output      pci_cfg_gpio_power_regs_pkg::cfg_rsp_t     cfgRsp,
	input  wire logic                                      auxPinAIn,
	output      logic                                      auxPinAOut,
	output      logic                                      auxPinAOe_n,
	input  wire logic                                      auxPinBIn,
	output      logic                                      auxPinBOut,
	output      logic                                      auxPinBOe_n,
	input  wire logic                                      primaryCodecSerialIn,
	input  wire logic                                      linkDown,
	input  wire logic                                      normalSync,
	input  wire logic                                      primaryGpInt,
	input  wire logic                                      secondaryGpInt,
	input  wire logic                                      eepromLoadValid,
	input  wire logic [31:0]                               eepromLoadData,
	output      logic                                      codecResetOut_n,
	output      logic                                      linkSyncOut,
	output      logic                                      secondaryInputSelect,
	output      logic                                      pmeOut,
	output      logic                                      pmeOe_n,
	output      logic                                      eepromEngineEnable,
	output      pci_cfg_gpio_power_regs_pkg::power_capability_t powerCapability,
	output      logic                                      globalTrapDisable,
	output      logic [2:0]                                irqPinAllow
);
	import pci_cfg_gpio_power_regs_pkg::*;

	logic [31:0] pinIo_r;
	logic [31:0] linkPower_r;
	logic [31:0] configBytes_r;
	logic [31:0] irqSelect_r;
	logic [SYNC_STAGES-1:0] syncA_r;
	logic [SYNC_STAGES-1:0] syncB_r;
	logic [SYNC_STAGES-1:0] syncPrim_r;
	logic        prevActA_r;
	logic        prevActB_r;
	logic        prevPrim_r;
	logic        prevSec_r;
	logic        prevPrimGp_r;
	logic        prevSecGp_r;
	logic        prevSync_r;
	logic        pinA;
	logic        pinB;
	logic        primIn;
	logic        activeA;
	logic        activeB;
	logic        secInEn;
	logic        pinAIsInput;
	logic        pinBIsInput;
	logic        wrOk;
	logic        syncFall;
	logic        clearA;
	logic        clearB;
	logic        clearPrimGp;
	logic        clearSecGp;
	logic        wakeAny;
	logic [31:0] pinIoRead;
	logic [31:0] byteMask;

	// Byte-enable lanes expanded to a bit mask.
	always_comb begin
		byteMask = {{8{cfgReq.byteEn[3]}}, {8{cfgReq.byteEn[2]}}, {8{cfgReq.byteEn[1]}}, {8{cfgReq.byteEn[0]}}};
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [31:0] lanes, input logic [31:0] mask);
		logic [31:0] m;
		m = lanes & mask;
		merge = (old & ~m) | (data & m);
	endfunction

	assign wrOk = cfgReq.wrEn & configWritePermission;

	assign pinA = syncA_r[SYNC_STAGES-1];
	assign pinB = syncB_r[SYNC_STAGES-1];
	assign primIn = syncPrim_r[SYNC_STAGES-1];

	// Pin inputs are synchronised; only the last stage is read.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			syncA_r <= '0;
			syncB_r <= '0;
			syncPrim_r <= '0;
		end else if (clkEn) begin
			syncA_r <= {syncA_r[SYNC_STAGES-2:0], auxPinAIn};
			syncB_r <= {syncB_r[SYNC_STAGES-2:0], auxPinBIn};
			syncPrim_r <= {syncPrim_r[SYNC_STAGES-2:0], primaryCodecSerialIn};
		end
	end

	assign secInEn = linkPower_r[`SLP_SEC_INPUT_EN];
	assign pinAIsInput = secInEn | ~pinIo_r[`PIO_A_OUT_EN];
	assign pinBIsInput = ~pinIo_r[`PIO_B_OUT_EN];
	assign activeA = pinIo_r[`PIO_A_POL_TYPE] ? pinA : ~pinA;
	assign activeB = pinIo_r[`PIO_B_POL_TYPE] ? pinB : ~pinB;
	assign syncFall = prevSync_r & ~linkSyncOut;

	// Writing 0 to a sticky status bit clears it.
	assign clearA = wrOk && cfgReq.addr == `OFS_EXTENDED_PIN_IO && cfgReq.byteEn[0] && !cfgReq.wrData[`PIO_A_STATUS];
	assign clearB = wrOk && cfgReq.addr == `OFS_EXTENDED_PIN_IO && cfgReq.byteEn[0] && !cfgReq.wrData[`PIO_B_STATUS];
	assign clearPrimGp = wrOk && cfgReq.addr == `OFS_EXTENDED_PIN_IO && cfgReq.byteEn[0] &&
		!cfgReq.wrData[`PIO_PRIM_GP_STATUS];
	assign clearSecGp = wrOk && cfgReq.addr == `OFS_EXTENDED_PIN_IO && cfgReq.byteEn[0] &&
		!cfgReq.wrData[`PIO_SEC_GP_STATUS];

	// Edge history for the sticky and wake detectors.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prevActA_r <= 1'b0;
			prevActB_r <= 1'b0;
			prevPrim_r <= 1'b0;
			prevSec_r <= 1'b0;
			prevPrimGp_r <= 1'b0;
			prevSecGp_r <= 1'b0;
			prevSync_r <= 1'b0;
		end else if (clkEn) begin
			prevActA_r <= activeA;
			prevActB_r <= activeB;
			prevPrim_r <= primIn;
			prevSec_r <= pinA;
			prevPrimGp_r <= primaryGpInt;
			prevSecGp_r <= secondaryGpInt;
			prevSync_r <= linkSyncOut;
		end
	end

	// Extended pin register: cleared by bus reset; a new edge wins over a clearing write.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pinIo_r <= `PIO_RESET;
		end else if (clkEn) begin
			if (wrOk && cfgReq.addr == `OFS_EXTENDED_PIN_IO) begin
				pinIo_r <= merge(pinIo_r, cfgReq.wrData, byteMask, `PIO_WR_MASK);
			end
			if (!pinIo_r[`PIO_A_STICKY] || !pinAIsInput || secInEn) begin
				pinIo_r[`PIO_A_STATUS] <= 1'b0;
			end else if (activeA && !prevActA_r) begin
				pinIo_r[`PIO_A_STATUS] <= 1'b1;
			end else if (clearA) begin
				pinIo_r[`PIO_A_STATUS] <= 1'b0;
			end
			if (!pinIo_r[`PIO_B_STICKY] || !pinBIsInput) begin
				pinIo_r[`PIO_B_STATUS] <= 1'b0;
			end else if (activeB && !prevActB_r) begin
				pinIo_r[`PIO_B_STATUS] <= 1'b1;
			end else if (clearB) begin
				pinIo_r[`PIO_B_STATUS] <= 1'b0;
			end
			if (primaryGpInt && !prevPrimGp_r) begin
				pinIo_r[`PIO_PRIM_GP_STATUS] <= 1'b1;
			end else if (clearPrimGp) begin
				pinIo_r[`PIO_PRIM_GP_STATUS] <= 1'b0;
			end
			if (secInEn && secondaryGpInt && !prevSecGp_r) begin
				pinIo_r[`PIO_SEC_GP_STATUS] <= 1'b1;
			end else if (clearSecGp) begin
				pinIo_r[`PIO_SEC_GP_STATUS] <= 1'b0;
			end
		end
	end

	// Link power register: only power-on clears it, bus reset leaves it alone.
	always_ff @(posedge clk_sys or negedge powerOnRst_n) begin
		if (!powerOnRst_n) begin
			linkPower_r <= `SLP_RESET;
		end else if (clkEn) begin
			if (wrOk && cfgReq.addr == `OFS_SERIAL_LINK_POWER) begin
				linkPower_r <= merge(linkPower_r, cfgReq.wrData, byteMask, `SLP_WR_MASK);
			end
			if (linkDown && primIn && !prevPrim_r) begin
				linkPower_r[`SLP_PRIM_WAKE_FLAG] <= 1'b1;
			end else if (syncFall) begin
				linkPower_r[`SLP_PRIM_WAKE_FLAG] <= 1'b0;
			end
			if (secInEn && linkDown && pinA && !prevSec_r) begin
				linkPower_r[`SLP_SEC_WAKE_FLAG] <= 1'b1;
			end else if (syncFall) begin
				linkPower_r[`SLP_SEC_WAKE_FLAG] <= 1'b0;
			end
		end
	end

	// Config bytes are preloaded by the EEPROM loader or by BIOS writes; nothing else reads them.
	always_ff @(posedge clk_sys or negedge powerOnRst_n) begin
		if (!powerOnRst_n) begin
			configBytes_r <= `CLB_RESET;
		end else if (clkEn) begin
			if (eepromLoadValid && !linkPower_r[`SLP_EEPROM_DISABLE]) begin
				configBytes_r <= eepromLoadData;
			end else if (wrOk && cfgReq.addr == `OFS_CONFIG_LOAD_BYTES) begin
				configBytes_r <= merge(configBytes_r, cfgReq.wrData, byteMask, `CLB_WR_MASK);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge powerOnRst_n) begin
		if (!powerOnRst_n) begin
			irqSelect_r <= `LIR_RESET;
		end else if (clkEn) begin
			if (wrOk && cfgReq.addr == `OFS_LEGACY_IRQ_SELECT) begin
				irqSelect_r <= merge(irqSelect_r, cfgReq.wrData, byteMask, `LIR_WR_MASK);
			end
		end
	end

	// Status bits show live qualified level, actual pin, or the latched edge; pin A reads zero while it is the secondary input.
	always_comb begin
		pinIoRead = pinIo_r;
		if (secInEn) begin
			pinIoRead[`PIO_A_STATUS] = 1'b0;
		end else if (!pinAIsInput) begin
			pinIoRead[`PIO_A_STATUS] = pinA;
		end else if (!pinIo_r[`PIO_A_STICKY]) begin
			pinIoRead[`PIO_A_STATUS] = activeA;
		end
		if (!pinBIsInput) begin
			pinIoRead[`PIO_B_STATUS] = pinB;
		end else if (!pinIo_r[`PIO_B_STICKY]) begin
			pinIoRead[`PIO_B_STATUS] = activeB;
		end
	end

	// Read answer one cycle after the request; unmapped offsets read zero.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfgRsp <= '0;
		end else if (clkEn) begin
			cfgRsp.valid <= cfgReq.rdEn;
			case (cfgReq.addr)
				`OFS_EXTENDED_PIN_IO: begin
					cfgRsp.data <= pinIoRead;
				end
				`OFS_SERIAL_LINK_POWER: begin
					cfgRsp.data <= linkPower_r;
				end
				`OFS_CONFIG_LOAD_BYTES: begin
					cfgRsp.data <= configBytes_r;
				end
				`OFS_LEGACY_IRQ_SELECT: begin
					cfgRsp.data <= irqSelect_r;
				end
				default: begin
					cfgRsp.data <= 32'h00000000;
				end
			endcase
		end
	end

	// Pin drivers: open drain releases on a high, the shared pin never drives as codec input.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			auxPinAOut <= 1'b0;
			auxPinAOe_n <= 1'b1;
			auxPinBOut <= 1'b0;
			auxPinBOe_n <= 1'b1;
		end else if (clkEn) begin
			auxPinAOut <= pinIo_r[`PIO_A_OUT_DATA];
			auxPinAOe_n <= pinAIsInput | (pinIo_r[`PIO_A_POL_TYPE] & pinIo_r[`PIO_A_OUT_DATA]);
			auxPinBOut <= pinIo_r[`PIO_B_OUT_DATA];
			auxPinBOe_n <= pinBIsInput | (pinIo_r[`PIO_B_POL_TYPE] & pinIo_r[`PIO_B_OUT_DATA]);
		end
	end

	// Bus reset forces the codec reset at once through the asynchronous clear.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			codecResetOut_n <= 1'b0;
		end else if (clkEn) begin
			codecResetOut_n <= linkPower_r[`SLP_CODEC_RESET_NOT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			linkSyncOut <= 1'b0;
		end else if (clkEn) begin
			linkSyncOut <= linkPower_r[`SLP_FORCE_SYNC] | normalSync;
		end
	end

	assign wakeAny =
		(pinIo_r[`PIO_A_WAKE] & pinIo_r[`PIO_A_STICKY] & ~secInEn & pinIo_r[`PIO_A_STATUS]) |
		(pinIo_r[`PIO_B_WAKE] & pinIo_r[`PIO_B_STICKY] & pinIo_r[`PIO_B_STATUS]) |
		(linkPower_r[`SLP_PRIM_IRQ_WAKE_EN] & pinIo_r[`PIO_PRIM_GP_STATUS]) |
		(linkPower_r[`SLP_SEC_IRQ_WAKE_EN] & pinIo_r[`PIO_SEC_GP_STATUS]) |
		linkPower_r[`SLP_PRIM_WAKE_FLAG] | linkPower_r[`SLP_SEC_WAKE_FLAG];

	// Event pin is open drain: it only ever pulls low.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pmeOut <= 1'b0;
			pmeOe_n <= 1'b1;
		end else if (clkEn) begin
			pmeOut <= 1'b0;
			pmeOe_n <= ~wakeAny;
		end
	end

	// Static mirrors of configuration fields toward other blocks.
	always_ff @(posedge clk_sys or negedge powerOnRst_n) begin
		if (!powerOnRst_n) begin
			secondaryInputSelect <= 1'b0;
			eepromEngineEnable <= 1'b0;
			powerCapability <= '0;
			globalTrapDisable <= 1'b0;
			irqPinAllow <= 3'h0;
		end else if (clkEn) begin
			secondaryInputSelect <= secInEn;
			eepromEngineEnable <= ~linkPower_r[`SLP_EEPROM_DISABLE];
			powerCapability.d3ColdSupport <= irqSelect_r[`LIR_AUX_SUPPLY];
			powerCapability.auxPowerFlag <= irqSelect_r[`LIR_AUX_POWER];
			powerCapability.auxCurrentCode <= irqSelect_r[`LIR_AUX_CURRENT_HI:`LIR_AUX_CURRENT_LO];
			globalTrapDisable <= irqSelect_r[`LIR_GLOBAL_TRAP_DIS];
			irqPinAllow[0] <= |irqSelect_r[`LIR_MAP_FIRST_LO+3:`LIR_MAP_FIRST_LO];
			irqPinAllow[1] <= |irqSelect_r[`LIR_MAP_SECOND_LO+3:`LIR_MAP_SECOND_LO];
			irqPinAllow[2] <= |irqSelect_r[`LIR_MAP_THIRD_LO+3:`LIR_MAP_THIRD_LO];
		end
	end
endmodule

//--- pci_cfg_gpio_power_regs_defines.svh
// Offsets, field positions, masks and reset values of the configuration register group.
// Assumes inclusion by bare name from the package, the checker and the bench.
`ifndef PCI_CFG_GPIO_POWER_REGS_DEFINES_SVH
`define PCI_CFG_GPIO_POWER_REGS_DEFINES_SVH

`define OFS_EXTENDED_PIN_IO     8'hE8
`define OFS_SERIAL_LINK_POWER   8'hEC
`define OFS_CONFIG_LOAD_BYTES   8'hF0
`define OFS_LEGACY_IRQ_SELECT   8'hF4

`define PIO_B_WAKE              31
`define PIO_B_STICKY            30
`define PIO_B_POL_TYPE          29
`define PIO_B_OUT_EN            28
`define PIO_A_WAKE              27
`define PIO_A_STICKY            26
`define PIO_A_POL_TYPE          25
`define PIO_A_OUT_EN            24
`define PIO_B_OUT_DATA          11
`define PIO_A_OUT_DATA          10
`define PIO_PRIM_GP_STATUS      5
`define PIO_SEC_GP_STATUS       4
`define PIO_B_STATUS            3
`define PIO_A_STATUS            2
`define PIO_WR_MASK             32'hFF000C00
`define PIO_RESET               32'h00000000

`define SLP_PRIM_IRQ_WAKE_EN    15
`define SLP_SEC_IRQ_WAKE_EN     14
`define SLP_EEPROM_DISABLE      9
`define SLP_SEC_INPUT_EN        8
`define SLP_SEC_WAKE_FLAG       3
`define SLP_PRIM_WAKE_FLAG      2
`define SLP_FORCE_SYNC          1
`define SLP_CODEC_RESET_NOT     0
`define SLP_WR_MASK             32'h0000C303
`define SLP_RESET               32'h00000000

`define CLB_WR_MASK             32'hFFFFFFFF
`define CLB_RESET               32'h00000000

`define LIR_AUX_SUPPLY          31
`define LIR_AUX_CURRENT_HI      30
`define LIR_AUX_CURRENT_LO      28
`define LIR_AUX_POWER           27
`define LIR_GLOBAL_TRAP_DIS     23
`define LIR_MAP_THIRD_LO        16
`define LIR_MAP_SECOND_LO       8
`define LIR_MAP_FIRST_LO        0
`define LIR_WR_MASK             32'hFF8F0F0F
`define LIR_RESET               32'h00000000

`endif

//--- pci_cfg_gpio_power_regs_pkg.sv
// Types shared by the configuration register group and its users.
// Assumes the defines header sits in the include path.
package pci_cfg_gpio_power_regs_pkg;
	`include "pci_cfg_gpio_power_regs_defines.svh"

	typedef struct packed {
		logic        wrEn;
		logic        rdEn;
		logic [7:0]  addr;
		logic [3:0]  byteEn;
		logic [31:0] wrData;
	} cfg_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} cfg_rsp_t;

	typedef struct packed {
		logic       d3ColdSupport;
		logic [2:0] auxCurrentCode;
		logic       auxPowerFlag;
	} power_capability_t;
endpackage

//--- pci_cfg_gpio_power_regs_props.sv
// Port-level checks of the configuration register group.
// Assumes a bind onto the register group; one clock, two active-low resets.
`timescale 1ns/1ps
`include "pci_cfg_gpio_power_regs_defines.svh"
module pci_cfg_gpio_power_regs_props (
	input wire logic                                           clk_sys,
	input wire logic                                           rst_n,
	input wire logic                                           powerOnRst_n,
	input wire logic                                           clkEn,
	input wire logic                                           configWritePermission,
	input wire pci_cfg_gpio_power_regs_pkg::cfg_req_t          cfgReq,
	input wire pci_cfg_gpio_power_regs_pkg::cfg_rsp_t          cfgRsp,
	input wire logic                                           auxPinBOut,
	input wire logic                                           auxPinBOe_n,
	input wire logic                                           codecResetOut_n,
	input wire logic                                           linkSyncOut,
	input wire logic                                           normalSync,
	input wire logic                                           secondaryInputSelect,
	input wire logic                                           eepromEngineEnable,
	input wire pci_cfg_gpio_power_regs_pkg::power_capability_t powerCapability,
	input wire logic                                           globalTrapDisable,
	input wire logic [2:0]                                     irqPinAllow
);
	import pci_cfg_gpio_power_regs_pkg::*;
	logic        wrOk, wrEc, wrF4, wrE8;
	logic [31:0] wd;
	assign wd = cfgReq.wrData;
	assign wrOk = clkEn && cfgReq.wrEn && configWritePermission && cfgReq.byteEn == 4'hF;
	assign wrEc = wrOk && cfgReq.addr == `OFS_SERIAL_LINK_POWER;
	assign wrF4 = wrOk && cfgReq.addr == `OFS_LEGACY_IRQ_SELECT;
	assign wrE8 = wrOk && cfgReq.addr == `OFS_EXTENDED_PIN_IO;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n || !powerOnRst_n);

	a_codec_reset: assert property (wrEc |=> ##1 codecResetOut_n == $past(wd[0], 2))
		else $error("codec reset off its bit");
	a_sync_forced: assert property (wrEc && wd[1] |=> ##1 linkSyncOut)
		else $error("forced sync not high");
	a_sync_normal: assert property (clkEn && normalSync |=> linkSyncOut)
		else $error("normal sync lost");
	a_sel_input: assert property (wrEc |=> ##1 secondaryInputSelect == $past(wd[8], 2))
		else $error("shared pin select wrong");
	a_eeprom_enable: assert property (wrEc |=> ##1 eepromEngineEnable == !$past(wd[9], 2))
		else $error("eeprom engine enable wrong");
	a_aux_mirror: assert property (wrF4 |=> ##1 powerCapability == $past(wd[31:27], 2))
		else $error("capability mirror wrong");
	a_trap_disable: assert property (wrF4 |=> ##1 globalTrapDisable == $past(wd[23], 2))
		else $error("trap disable mirror wrong");
	a_irq_allow: assert property (wrF4 |=> ##1 irqPinAllow == {|$past(wd[19:16], 2), |$past(wd[11:8], 2),
		|$past(wd[3:0], 2)})
		else $error("irq pin allow wrong");
	a_pin_b_drive: assert property (wrE8 && wd[28] && !wd[29] |=> ##1 !auxPinBOe_n &&
		auxPinBOut == $past(wd[11], 2))
		else $error("pin b not driven");
	a_pin_b_input: assert property (wrE8 && !wd[28] |=> ##1 auxPinBOe_n)
		else $error("pin b driven as input");
	a_read_answer: assert property (clkEn |=> cfgRsp.valid == $past(cfgReq.rdEn))
		else $error("read answer timing wrong");
	a_write_refused: assert property (clkEn && cfgReq.wrEn && !configWritePermission
		&& cfgReq.addr == `OFS_SERIAL_LINK_POWER |=> ##1 $stable(codecResetOut_n) && $stable(secondaryInputSelect))
		else $error("refused write took effect");

	c_irq_write: cover property (wrF4);
	c_link_write: cover property (wrEc && wd[1]);
	c_read: cover property (clkEn && cfgReq.rdEn);
endmodule

//--- pin_board_model.sv
// Board model of one extended pin: pull-up, an outside driver and the block's own driver.
// Assumes an active-low output enable from the register group.
`timescale 1ns/1ps
module pin_board_model (
	input  wire logic oe_n,
	input  wire logic drv,
	input  wire logic extEn,
	input  wire logic extVal,
	output      logic pin
);
	// A released line, an open-drain high among them, follows the outside driver when it is enabled, else the pull-up level.
	assign pin = !oe_n ? drv : (extEn ? extVal : 1'b1);
endmodule

//--- tb_pci_cfg_gpio_power_regs.sv
// Self-checking bench of the configuration register group: registers, pins, wake and codec link.
// Assumes the package, design, pin model and checker are compiled before it.
`timescale 1ns/1ps
`include "pci_cfg_gpio_power_regs_defines.svh"
module tb_pci_cfg_gpio_power_regs;
	import pci_cfg_gpio_power_regs_pkg::*;
	logic              clk_sys, rst_n, powerOnRst_n, clkEn, configWritePermission;
	logic              auxPinAIn, auxPinAOut, auxPinAOe_n, auxPinBIn, auxPinBOut, auxPinBOe_n;
	logic              primaryCodecSerialIn, linkDown, normalSync, primaryGpInt, secondaryGpInt;
	logic              eepromLoadValid, codecResetOut_n, linkSyncOut, secondaryInputSelect, pmeOut, pmeOe_n;
	logic              eepromEngineEnable, globalTrapDisable, extAEn, extAVal, extBEn, extBVal;
	logic [2:0]        irqPinAllow;
	logic [3:0]        be;
	logic [31:0]       eepromLoadData, rdv, d;
	logic [31:0]       sh [3];
	logic [31:0]       rm [3] = '{`SLP_WR_MASK, `CLB_WR_MASK, `LIR_WR_MASK};
	logic [7:0]        ra [3] = '{`OFS_SERIAL_LINK_POWER, `OFS_CONFIG_LOAD_BYTES, `OFS_LEGACY_IRQ_SELECT};
	cfg_req_t          cfgReq;
	cfg_rsp_t          cfgRsp;
	power_capability_t powerCapability;
	int                err_total, n_tests;
	localparam logic [7:0] EC = `OFS_SERIAL_LINK_POWER;
	localparam logic [7:0] E8 = `OFS_EXTENDED_PIN_IO;

	pci_cfg_gpio_power_regs #(.SYNC_STAGES(2)) i_pci_cfg_gpio_power_regs (.*);
	pin_board_model i_pin_a (.oe_n(auxPinAOe_n), .drv(auxPinAOut), .extEn(extAEn), .extVal(extAVal), .pin(auxPinAIn));
	pin_board_model i_pin_b (.oe_n(auxPinBOe_n), .drv(auxPinBOut), .extEn(extBEn), .extVal(extBVal), .pin(auxPinBIn));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
		@(posedge clk_sys);
		cfgReq <= '{1'b1, 1'b0, a, b, v};
		@(posedge clk_sys);
		cfgReq.wrEn <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		cfgReq <= '{1'b0, 1'b1, a, 4'hF, 32'h0};
		@(posedge clk_sys);
		cfgReq.rdEn <= 1'b0;
		#1;
		rdv = cfgRsp.data;
		chk(cfgRsp.valid, 1);
		@(posedge clk_sys);
	endtask
	task automatic note(input string s);
		$display("test done: %s", s);
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Byte-lane merge of a write into the expected register image.
	function automatic logic [31:0] merge(input logic [31:0] o, v, m, input logic [3:0] b);
		for (int i = 0; i < 4; i++)
			if (b[i]) o[8*i +: 8] = (v[8*i +: 8] & m[8*i +: 8]) | (o[8*i +: 8] & ~m[8*i +: 8]);
		return o;
	endfunction

	initial begin
		err_total = 0;
		n_tests = 0;
		{rst_n, powerOnRst_n, configWritePermission, linkDown, normalSync, primaryGpInt} = '0;
		{secondaryGpInt, primaryCodecSerialIn, eepromLoadValid, extAEn, extAVal, extBEn, extBVal} = '0;
		clkEn = 1'b1;
		cfgReq = '0;
		eepromLoadData = '0;
		d = $urandom(14437);
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		powerOnRst_n <= 1'b1;
		tick(2);
		#1 chk({codecResetOut_n, eepromEngineEnable}, 2'b01);
		foreach (ra[j]) begin
			rd(ra[j]);
			chk(rdv, 0);
			sh[j] = 0;
		end
		rd(E8);
		chk(rdv, `PIO_RESET);
		rd(8'h00);
		chk(rdv, 0);
		note("reset values");
		for (int i = 0; i < 12; i++) begin
			foreach (ra[j]) begin
				configWritePermission <= (i % 3) != 1;
				d = (i == 0) ? 32'h80800F00 : $urandom;
				be = (i % 4 == 0) ? 4'hF : 4'($urandom);
				normalSync <= 1'($urandom);
				wr(ra[j], be, d);
				if ((i % 3) != 1) sh[j] = merge(sh[j], d, rm[j], be);
				rd(ra[j]);
				chk(rdv, sh[j]);
			end
			chk(powerCapability, sh[2][31:27]);
			chk({globalTrapDisable, irqPinAllow}, {sh[2][23], |sh[2][19:16], |sh[2][11:8], |sh[2][3:0]});
		end
		normalSync <= 1'b0;
		note("random register traffic");
		rst_n <= 1'b0;
		tick(2);
		#1 chk(codecResetOut_n, 0);
		@(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (ra[j]) begin
			rd(ra[j]);
			chk(rdv, sh[j]);
		end
		wr(EC, 4'hF, 32'h1);
		tick(2);
		#1 chk(codecResetOut_n, 1);
		note("bus reset");
		d = $urandom;
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			eepromLoadValid <= 1'b1;
			eepromLoadData <= k ? ~d : d;
			@(posedge clk_sys);
			eepromLoadValid <= 1'b0;
			rd(`OFS_CONFIG_LOAD_BYTES);
			chk(rdv, d);
			wr(EC, 4'hF, 32'h201);
			tick(2);
			#1 chk(eepromEngineEnable, 0);
		end
		wr(EC, 4'hF, 32'h1);
		note("eeprom load");
		wr(E8, 4'hF, 32'hC0000000);
		extBEn <= 1'b1;
		tick(6);
		#1 chk(pmeOe_n, 0);
		extBEn <= 1'b0;
		tick(6);
		rd(E8);
		chk(rdv[`PIO_B_STATUS], 1);
		wr(E8, 4'hF, 32'h20000000);
		tick(4);
		rd(E8);
		chk({rdv[`PIO_B_STATUS], pmeOe_n}, 2'b11);
		extBEn <= 1'b1;
		tick(4);
		rd(E8);
		chk(rdv[`PIO_B_STATUS], 0);
		extBEn <= 1'b0;
		wr(E8, 4'hF, 32'h10000800);
		tick(2);
		#1 chk({auxPinBOe_n, auxPinBOut}, 2'b01);
		wr(E8, 4'hF, 32'h30000800);
		tick(2);
		#1 chk(auxPinBOe_n, 1);
		wr(E8, 4'hF, 32'h30000000);
		tick(2);
		#1 chk({auxPinBOe_n, auxPinBOut}, 2'b00);
		note("pin b");
		wr(EC, 4'hF, 32'h101);
		wr(E8, 4'hF, 32'h0C000000);
		extAEn <= 1'b1;
		tick(6);
		#1 chk({pmeOe_n, secondaryInputSelect}, 2'b11);
		extAEn <= 1'b0;
		tick(4);
		wr(EC, 4'hF, 32'h1);
		extAEn <= 1'b1;
		tick(6);
		rd(E8);
		chk({rdv[`PIO_A_STATUS], pmeOe_n}, 2'b10);
		extAEn <= 1'b0;
		wr(E8, 4'hF, 32'h0);
		wr(E8, 4'hF, 32'h01000400);
		tick(2);
		#1 chk({auxPinAOe_n, auxPinAOut, pmeOut}, 3'b010);
		wr(E8, 4'hF, 32'h03000400);
		tick(2);
		#1 chk(auxPinAOe_n, 1);
		wr(E8, 4'hF, 32'h0);
		note("pin a");
		wr(EC, 4'hF, 32'h101);
		extAEn <= 1'b1;
		tick(4);
		{linkDown, primaryCodecSerialIn, extAEn} <= 3'b110;
		tick(6);
		rd(EC);
		chk({rdv[3:2], pmeOe_n}, 3'b110);
		linkDown <= 1'b0;
		wr(EC, 4'hF, 32'h103);
		tick(2);
		#1 chk(linkSyncOut, 1);
		wr(EC, 4'hF, 32'h101);
		tick(3);
		rd(EC);
		chk({rdv[3:2], pmeOe_n}, 3'b001);
		primaryCodecSerialIn <= 1'b0;
		note("codec wake");
		for (int k = 0; k < 2; k++) begin
			wr(EC, 4'hF, k ? 32'h4101 : 32'h8001);
			{primaryGpInt, secondaryGpInt} <= k ? 2'b01 : 2'b10;
			tick(4);
			rd(E8);
			chk({rdv[5-k], pmeOe_n}, 2'b10);
			{primaryGpInt, secondaryGpInt} <= 2'b00;
			wr(E8, 4'hF, 32'h0);
			tick(2);
			#1 chk(pmeOe_n, 1);
		end
		note("codec interrupt wake");
		@(posedge clk_sys);
		configWritePermission <= 1'b1;
		clkEn <= 1'b0;
		wr(`OFS_CONFIG_LOAD_BYTES, 4'hF, ~d);
		clkEn <= 1'b1;
		rd(`OFS_CONFIG_LOAD_BYTES);
		chk(rdv, d);
		note("clock enable low");
		results();
	end

	// The sequence needs well under three thousand cycles; this bound leaves wide margin.
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		results();
	end
endmodule

bind pci_cfg_gpio_power_regs pci_cfg_gpio_power_regs_props i_pci_cfg_gpio_power_regs_props (.*);
